/* File: core/recorder_map.svh */
// Register offsets, field positions, reset values and timing figures of the recorder.
// Assumes inclusion by bare name from the recorder and its verification sources.
`ifndef RECORDER_MAP_SVH
`define RECORDER_MAP_SVH

// Byte offsets on the register port.
`define REG_CTRL 8'h00
`define REG_PRETRIG 8'h04
`define REG_STATUS 8'h08
`define REG_RDSEL 8'h0C
`define REG_RDDATA 8'h10

// Control word fields.
`define CTRL_SET_LSB 0
`define CTRL_TRIG_LSB 4
`define CTRL_CLEAR_BIT 8

// Read select fields.
`define RDSEL_SEG_LSB 0
`define RDSEL_IDX_LSB 16

// Status word fields.
`define STAT_COUNT_LSB 0
`define STAT_OLDEST_LSB 4
`define STAT_NEWEST_LSB 8
`define STAT_BUSY_BIT 12
`define STAT_FULL_BIT 13
`define STAT_TEST_BIT 14

// Reset values.
`define CTRL_SETTING_RST 4'h1
`define PRETRIG_RST 16'h0010

// Whole store: 16 s at 50 Hz, which is also 13.33 s at 60 Hz.
`define REC_SECONDS_50HZ 16
`define LINE_HZ_LOW 50
`define REC_PERIODS (`REC_SECONDS_50HZ * `LINE_HZ_LOW)

// Least pre-trigger time, rounded up at the faster line rate.
`define PRE_MIN_MS 50
`define LINE_HZ_HIGH 60

`endif

/* File: core/recorder_pkg.sv */
// Types shared by the disturbance recorder and its verification models.
// Assumes nothing of its surroundings.
`default_nettype none

package recorder_pkg;
    typedef logic [31:0] reg_word_t;
    typedef logic [7:0] reg_addr_t;

    typedef enum logic [1:0] {
        ST_ARMED,
        ST_POST,
        ST_FULL
    } rec_state_e;

    typedef enum logic [1:0] {
        TRIG_PICKUP,
        TRIG_TRIP,
        TRIG_AFTER_PICKUP,
        TRIG_TEST
    } trig_sel_e;

    typedef struct packed {
        logic valid;
        logic overwrite;
        logic [1:0] segShift;
    } cfg_s;
endpackage

`default_nettype wire

/* File: core/segment_memory.sv */
// Flip-flop sample store: one write port, one asynchronous read port.
// Assumes the writer keeps the address below DEPTH; reads beyond it return zero.
`default_nettype none

module segment_memory #(
    parameter int DEPTH = 800,
    parameter int W = 18,
    parameter int AW = 10
) (
    // Clock
    input wire logic clock,
    // Write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [W-1:0] wrData,
    // Read port
    input wire logic [AW-1:0] rdAddr,
    output logic [W-1:0] rdData
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] cells;
    } mem_s;

    mem_s mem_ff;
    mem_s nxt_mem;

    ////////////////////////////////////////////////////////////////////////////
    // Sample storage is left unreset: its contents only matter once a
    // recording has been completed over it.
    always_comb begin
        nxt_mem = mem_ff;
        if (wrEn && (int'(wrAddr) < DEPTH)) begin
            nxt_mem.cells[wrAddr] = wrData;
        end
    end

    always_ff @(posedge clock) begin
        mem_ff <= nxt_mem;
    end

    assign rdData = (int'(rdAddr) < DEPTH) ? mem_ff.cells[rdAddr] : '0;

endmodule

`default_nettype wire

/* File: core/fault_disturbance_recorder.sv */
// Disturbance recorder: segmented ring store with pre- and post-trigger capture.
// Assumes a sample strobe and protection flags on the same clock, keys from pins.
//
// Operation
// (RL1) Non-overwriting mode keeps all, refuses when full.
// (RL2) Overwriting mode replaces the oldest recording.
// (RL3) Whole store holds 800 line periods.
// (RL4) Two, four or eight equal segments.
// (RL5) Setting 1/3/7 overwrites, 2/4/8 does not.
// (RL6) Overwriting keeps one segment spare as buffer.
// (RL7) Free segment captures samples while awaiting trigger.
// (RL8) Segment time fixed, pre-trigger part settable.
// (RL9) Pre-trigger from 0.05 s to segment length.
// (RL10) Pickup trigger: general activation starts recording.
// (RL11) Trip trigger: general trip starts recording.
// (RL12) After-pickup trigger: last activation dropping out.
// (RL13) Test trigger on both keys, indication while recording.
// (RL14) Activation and trip tracks stored with samples.
// (RL15) Host reads recordings out; host starts readout.
// (RL16) Segment pointer advances; oldest and newest tracked.
// (RL17) Triggers ignored during post-trigger capture.
`default_nettype none

`include "recorder_map.svh"

module fault_disturbance_recorder #(
    parameter int SAMPLE_W = 16,
    parameter int SAMPLES_PER_PERIOD = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Sample stream
    input wire logic sampleStrobe,
    input wire logic [SAMPLE_W-1:0] sampleData,
    // Protection state
    input wire logic pickupAny,
    input wire logic tripAny,
    // Front-panel keys
    input wire logic keyPlus,
    input wire logic keyMinus,
    // Register port
    input wire recorder_pkg::reg_addr_t regAddr,
    input wire recorder_pkg::reg_word_t regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output recorder_pkg::reg_word_t regRdData,
    // Status
    output logic testShow,
    output logic recordBusy
);
    import recorder_pkg::*;

    localparam int DEPTH = `REC_PERIODS * SAMPLES_PER_PERIOD; // RL3
    localparam int AW = $clog2(DEPTH);
    localparam int EW = SAMPLE_W + 2;
    localparam int PRE_MIN_CYC =
        (`PRE_MIN_MS * `LINE_HZ_HIGH * SAMPLES_PER_PERIOD + 999) / 1000;

    typedef logic [AW-1:0] idx_t;

    localparam idx_t PRE_MIN = idx_t'(PRE_MIN_CYC);
    localparam idx_t ONE = idx_t'(1);

    typedef struct packed {
        rec_state_e state;
        logic [3:0] setting;
        trig_sel_e trigSel;
        logic [15:0] preSamples;
        logic [2:0] curSeg;
        logic [2:0] oldest;
        logic [2:0] newest;
        logic [3:0] count;
        idx_t wrOff;
        idx_t postLeft;
        logic testRun;
        logic [7:0][AW-1:0] startOff;
        logic prevPick;
        logic prevTrip;
        logic prevKeys;
        logic [1:0] keySync1;
        logic [1:0] keySync2;
        logic [2:0] rdSeg;
        idx_t rdIdx;
        reg_word_t rdData;
    } rec_s;

    rec_s rec_ff;
    rec_s nxt_rec;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic cfg_s decodeSetting(input logic [3:0] s);
        cfg_s c;
        c = '{valid: 1'b1, overwrite: 1'b0, segShift: 2'd1};
        unique case (s)
            4'h1: c = '{valid: 1'b1, overwrite: 1'b1, segShift: 2'd1}; // RL5
            4'h2: c = '{valid: 1'b1, overwrite: 1'b0, segShift: 2'd1};
            4'h3: c = '{valid: 1'b1, overwrite: 1'b1, segShift: 2'd2};
            4'h4: c = '{valid: 1'b1, overwrite: 1'b0, segShift: 2'd2};
            4'h7: c = '{valid: 1'b1, overwrite: 1'b1, segShift: 2'd3};
            4'h8: c = '{valid: 1'b1, overwrite: 1'b0, segShift: 2'd3};
            default: c.valid = 1'b0;
        endcase
        return c;
    endfunction

    // Both operands must already lie below len.
    function automatic idx_t wrapAdd(input idx_t a, input idx_t b, input idx_t len);
        logic [AW:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        if (sum >= {1'b0, len}) begin
            sum = sum - {1'b0, len};
        end
        return sum[AW-1:0];
    endfunction

    function automatic idx_t segAddr(input logic [2:0] seg, input idx_t off,
                                     input idx_t len);
        logic [AW+3:0] full;
        full = (AW+4)'(seg) * (AW+4)'(len) + (AW+4)'(off);
        return full[AW-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Derived configuration and trigger detection.

    cfg_s cfg;
    idx_t segLen;
    logic [3:0] segCount;
    logic [2:0] segMask;
    logic [3:0] retain;
    idx_t preClamp;
    idx_t postLen;
    logic bothKeys;
    logic fire;
    logic memWrEn;
    idx_t memWrAddr;
    logic [EW-1:0] memWrData;
    idx_t memRdAddr;
    logic [EW-1:0] memRdData;
    idx_t nxtOff;
    cfg_s wrCfg;

    always_comb begin
        cfg = decodeSetting(rec_ff.setting);
        segLen = idx_t'(DEPTH >> cfg.segShift); // RL4
        segCount = 4'h1 << cfg.segShift;
        segMask = 3'(segCount - 4'h1);
        retain = cfg.overwrite ? segCount - 4'h1 : segCount; // RL6
        preClamp = idx_t'(rec_ff.preSamples); // RL9
        if ((rec_ff.preSamples < 16'(PRE_MIN)) || (PRE_MIN > segLen)) begin
            preClamp = (PRE_MIN > segLen) ? segLen : PRE_MIN;
        end else if (rec_ff.preSamples > 16'(segLen)) begin
            preClamp = segLen;
        end
        postLen = segLen - preClamp; // RL8
        if (postLen == '0) begin
            postLen = ONE;
        end
        bothKeys = &rec_ff.keySync2;
        unique case (rec_ff.trigSel)
            TRIG_PICKUP: fire = pickupAny && !rec_ff.prevPick; // RL10
            TRIG_TRIP: fire = tripAny && !rec_ff.prevTrip; // RL11
            TRIG_AFTER_PICKUP: fire = !pickupAny && rec_ff.prevPick; // RL12
            TRIG_TEST: fire = bothKeys && !rec_ff.prevKeys; // RL13
        endcase
        nxtOff = wrapAdd(rec_ff.wrOff, ONE, segLen);
        memWrAddr = segAddr(rec_ff.curSeg, rec_ff.wrOff, segLen);
        memWrData = {tripAny, pickupAny, sampleData}; // RL14
        memRdAddr = segAddr(rec_ff.rdSeg,
                            wrapAdd(rec_ff.startOff[rec_ff.rdSeg], rec_ff.rdIdx, segLen),
                            segLen);
        wrCfg = decodeSetting(regWrData[`CTRL_SET_LSB +: 4]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture sequence and register port.

    always_comb begin
        nxt_rec = rec_ff;
        memWrEn = 1'b0;
        nxt_rec.keySync1 = {keyPlus, keyMinus};
        nxt_rec.keySync2 = rec_ff.keySync1;
        nxt_rec.prevPick = pickupAny;
        nxt_rec.prevTrip = tripAny;
        nxt_rec.prevKeys = bothKeys;

        unique case (rec_ff.state)
            ST_ARMED: begin
                if (sampleStrobe) begin
                    memWrEn = 1'b1; // RL7
                    nxt_rec.wrOff = nxtOff;
                end
                if (fire) begin
                    nxt_rec.state = ST_POST;
                    nxt_rec.postLeft = postLen;
                    nxt_rec.testRun = (rec_ff.trigSel == TRIG_TEST); // RL13
                end
            end
            ST_POST: begin
                // Fresh triggers are not looked at in this state.
                if (sampleStrobe) begin // RL17
                    memWrEn = 1'b1;
                    nxt_rec.wrOff = nxtOff;
                    nxt_rec.postLeft = rec_ff.postLeft - ONE;
                    if (rec_ff.postLeft == ONE) begin
                        // The oldest sample of the ring sits just past the last write.
                        nxt_rec.startOff[rec_ff.curSeg] = nxtOff;
                        nxt_rec.newest = rec_ff.curSeg; // RL16
                        nxt_rec.curSeg = (rec_ff.curSeg + 3'h1) & segMask;
                        nxt_rec.wrOff = '0;
                        nxt_rec.testRun = 1'b0;
                        nxt_rec.state = ST_ARMED;
                        if (rec_ff.count == retain) begin
                            nxt_rec.oldest = (rec_ff.oldest + 3'h1) & segMask; // RL2
                        end else begin
                            nxt_rec.count = rec_ff.count + 4'h1;
                        end
                        if (!cfg.overwrite && (rec_ff.count + 4'h1 == segCount)) begin
                            nxt_rec.state = ST_FULL; // RL1
                        end
                    end
                end
            end
            ST_FULL: begin
                nxt_rec.state = ST_FULL; // RL1
            end
            default: begin
                nxt_rec.state = ST_ARMED;
            end
        endcase

        // Software writes come last so that a clear overrides a completion.
        if (regWrite) begin
            unique case (regAddr)
                `REG_CTRL: begin
                    nxt_rec.trigSel = trig_sel_e'(regWrData[`CTRL_TRIG_LSB +: 2]);
                    if (regWrData[`CTRL_CLEAR_BIT] ||
                        (wrCfg.valid && (regWrData[`CTRL_SET_LSB +: 4] != rec_ff.setting))) begin
                        if (wrCfg.valid) begin
                            nxt_rec.setting = regWrData[`CTRL_SET_LSB +: 4];
                        end
                        nxt_rec.state = ST_ARMED;
                        nxt_rec.curSeg = '0;
                        nxt_rec.oldest = '0;
                        nxt_rec.newest = '0;
                        nxt_rec.count = '0;
                        nxt_rec.wrOff = '0;
                        nxt_rec.testRun = 1'b0;
                    end
                end
                `REG_PRETRIG: nxt_rec.preSamples = regWrData[15:0];
                `REG_RDSEL: begin
                    nxt_rec.rdSeg = regWrData[`RDSEL_SEG_LSB +: 3];
                    nxt_rec.rdIdx = regWrData[`RDSEL_IDX_LSB +: AW];
                end
                default: begin
                end
            endcase
        end

        nxt_rec.rdData = '0;
        if (regRead) begin
            unique case (regAddr)
                `REG_CTRL: begin
                    nxt_rec.rdData[`CTRL_SET_LSB +: 4] = rec_ff.setting;
                    nxt_rec.rdData[`CTRL_TRIG_LSB +: 2] = rec_ff.trigSel;
                end
                `REG_PRETRIG: nxt_rec.rdData[15:0] = rec_ff.preSamples;
                `REG_STATUS: begin
                    nxt_rec.rdData[`STAT_COUNT_LSB +: 4] = rec_ff.count;
                    nxt_rec.rdData[`STAT_OLDEST_LSB +: 3] = rec_ff.oldest; // RL16
                    nxt_rec.rdData[`STAT_NEWEST_LSB +: 3] = rec_ff.newest;
                    nxt_rec.rdData[`STAT_BUSY_BIT] = (rec_ff.state == ST_POST);
                    nxt_rec.rdData[`STAT_FULL_BIT] = (rec_ff.state == ST_FULL);
                    nxt_rec.rdData[`STAT_TEST_BIT] = rec_ff.testRun;
                end
                `REG_RDSEL: begin
                    nxt_rec.rdData[`RDSEL_SEG_LSB +: 3] = rec_ff.rdSeg;
                    nxt_rec.rdData[`RDSEL_IDX_LSB +: AW] = rec_ff.rdIdx;
                end
                `REG_RDDATA: begin
                    // Auto-increment lets the serial front end stream a segment.
                    nxt_rec.rdData[EW-1:0] = memRdData; // RL15
                    nxt_rec.rdIdx = wrapAdd(rec_ff.rdIdx, ONE, segLen);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rec_ff <= '0;
            rec_ff.state <= ST_ARMED;
            rec_ff.setting <= `CTRL_SETTING_RST;
            rec_ff.trigSel <= TRIG_PICKUP;
            rec_ff.preSamples <= `PRETRIG_RST;
        end else begin
            rec_ff <= nxt_rec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample store and outputs.

    segment_memory #(
        .DEPTH(DEPTH),
        .W(EW),
        .AW(AW)
    ) store (
        .clock(clock),
        .wrEn(memWrEn),
        .wrAddr(memWrAddr),
        .wrData(memWrData),
        .rdAddr(memRdAddr),
        .rdData(memRdData)
    );

    assign regRdData = rec_ff.rdData;
    assign testShow = rec_ff.testRun;
    assign recordBusy = (rec_ff.state == ST_POST);

endmodule

`default_nettype wire

/* File: verification/recorder_checker.sv */
// Port checker for the disturbance recorder.
// Assumes it is bound to the recorder top and sees only its ports.
`default_nettype none
`include "recorder_map.svh"

module recorder_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Stimulus side
    input wire logic sampleStrobe,
    input wire logic pickupAny,
    input wire logic tripAny,
    input wire logic keyPlus,
    input wire logic keyMinus,
    input wire recorder_pkg::reg_addr_t regAddr,
    input wire recorder_pkg::reg_word_t regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    // Design outputs
    input wire recorder_pkg::reg_word_t regRdData,
    input wire logic testShow,
    input wire logic recordBusy
);
    import recorder_pkg::*;
    logic [1:0] trigSel_ff;
    logic [3:0] setting_ff;
    logic bothKeys;
    logic stRead;
    assign bothKeys = keyPlus && keyMinus;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Shadow of the control word; illegal settings are dropped as the design does.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            trigSel_ff <= 2'h0;
            setting_ff <= `CTRL_SETTING_RST;
        end else if (regWrite && regAddr == `REG_CTRL) begin
            trigSel_ff <= regWrData[`CTRL_TRIG_LSB +: 2];
            if (regWrData[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8}) begin
                setting_ff <= regWrData[3:0];
            end
        end
    end
    always_ff @(posedge clock) begin
        stRead <= regRead && regAddr == `REG_STATUS;
    end

    ////////////////////////////////////////////////////////////////
    rd_idle_zero_a: assert property (!$past(regRead) |-> regRdData == 32'h0)
        else $error("read data not zero outside a read");
    busy_cause_a: assert property ($rose(recordBusy) |->
        (trigSel_ff == TRIG_PICKUP && $past(pickupAny) && !$past(pickupAny, 2)) ||
        (trigSel_ff == TRIG_TRIP && $past(tripAny) && !$past(tripAny, 2)) ||
        (trigSel_ff == TRIG_AFTER_PICKUP && !$past(pickupAny) && $past(pickupAny, 2)) ||
        (trigSel_ff == TRIG_TEST && $past(bothKeys, 3) && !$past(bothKeys, 4)))
        else $error("capture started without its trigger");
    test_show_a: assert property (testShow |-> recordBusy && trigSel_ff == TRIG_TEST)
        else $error("test indication outside a test capture");
    test_rise_a: assert property ($rose(recordBusy) && trigSel_ff == TRIG_TEST |-> testShow)
        else $error("test capture without indication");
    busy_end_a: assert property ($fell(recordBusy) |-> $past(sampleStrobe) || $past(regWrite))
        else $error("capture ended without a sample");
    busy_hold_a: assert property (recordBusy && !sampleStrobe && !regWrite |=> recordBusy)
        else $error("capture dropped between samples");
    status_live_a: assert property (stRead |->
        regRdData[`STAT_BUSY_BIT] == $past(recordBusy)
        && regRdData[`STAT_TEST_BIT] == $past(testShow))
        else $error("status flags disagree with outputs");
    count_bound_a: assert property (stRead |-> regRdData[3:0] <= $past(setting_ff))
        else $error("more recordings than the setting allows");
    full_flag_a: assert property (stRead && regRdData[`STAT_FULL_BIT] |->
        regRdData[3:0] == $past(setting_ff) && !$past(setting_ff[0]))
        else $error("full flag with wrong count or mode");

    cover property ($rose(recordBusy));
    cover property ($rose(testShow));
    cover property (stRead && regRdData[`STAT_FULL_BIT]);
endmodule

bind fault_disturbance_recorder recorder_checker i_recorder_checker (.clock, .sys_rst,
    .sampleStrobe, .pickupAny, .tripAny, .keyPlus, .keyMinus, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .testShow, .recordBusy);

`default_nettype wire

/* File: verification/host_pc_model.sv */
// Host PC model: reaches the recorder registers as the serial link would.
// Assumes the one-cycle strobe register port with no wait states.
`default_nettype none

module host_pc_model (
    // Clock
    input wire logic clock,
    // Register port
    output recorder_pkg::reg_addr_t regAddr,
    output recorder_pkg::reg_word_t regWrData,
    output logic regWrite,
    output logic regRead,
    input wire recorder_pkg::reg_word_t regRdData
);
    import recorder_pkg::*;
    initial begin
        regAddr = 8'h00;
        regWrData = 32'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
    end

    // Only the host starts a transfer; released lines show junk, not the last value.
    task automatic wr(input reg_addr_t a, input reg_word_t d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask

    task automatic rd(input reg_addr_t a, output reg_word_t d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(posedge clock);
        d = regRdData;
    endtask
endmodule

`default_nettype wire

/* File: verification/fault_disturbance_recorder_tb.sv */
// Self-checking bench for the disturbance recorder.
// Assumes one sample strobe every two clocks and one sample per line period.
`default_nettype none
`include "recorder_map.svh"

module fault_disturbance_recorder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import recorder_pkg::*;
    localparam logic [31:0] SETS[6] = '{1, 2, 3, 4, 7, 8};
    localparam logic [31:0] LENS[6] = '{400, 400, 200, 200, 100, 100};
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic sampleStrobe = 1'b0;
    logic [15:0] sampleData = 16'h0;
    logic pickupAny = 1'b0;
    logic tripAny = 1'b0;
    logic keyPlus = 1'b0;
    logic keyMinus = 1'b0;
    reg_addr_t regAddr;
    reg_word_t regWrData;
    logic regWrite;
    logic regRead;
    reg_word_t regRdData;
    logic testShow;
    logic recordBusy;
    logic [17:0] lastEntry = 18'h0;
    int badCount = 0;
    int samplesChecked = 0;

    fault_disturbance_recorder #(.SAMPLE_W(16), .SAMPLES_PER_PERIOD(1))
        i_fault_disturbance_recorder (.clock, .sys_rst, .sampleStrobe, .sampleData,
        .pickupAny, .tripAny, .keyPlus, .keyMinus, .regAddr, .regWrData, .regWrite,
        .regRead, .regRdData, .testShow, .recordBusy);
    host_pc_model i_host_pc_model (.clock, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData);

    always #5 clock = ~clock;
    // The last strobe seen during a capture is the newest entry of its segment.
    always @(posedge clock) begin
        sampleStrobe <= !sampleStrobe && !sys_rst;
        sampleData <= sampleStrobe ? sampleData : sampleData + 16'h1;
        if (sampleStrobe && recordBusy) begin
            lastEntry <= {tripAny, pickupAny, sampleData};
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic rdc(input reg_addr_t a, input string what, input reg_word_t e);
        reg_word_t d;
        i_host_pc_model.rd(a, d);
        chk(what, e, d);
    endtask
    // Counts post-trigger strobes; gives up if no capture starts within 22 clocks.
    task automatic capture(output int n, output logic t);
        bit seen;
        n = 0;
        t = 1'b1;
        seen = 1'b0;
        for (int k = 0; k < 2000; k++) begin
            @(posedge clock);
            if (recordBusy === 1'b1) begin
                seen = 1'b1;
                t = t & testShow;
                n = n + int'(sampleStrobe === 1'b1);
            end else if (seen || k > 20) begin
                break;
            end
        end
    endtask
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_modes();
        reg_word_t d;
        rdc(`REG_CTRL, "ctrl reset", 32'h1);
        rdc(`REG_PRETRIG, "pretrig reset", 32'h10);
        rdc(`REG_STATUS, "status reset", 32'h0);
        rdc(8'h14, "unmapped", 32'h0);
        // The pre-trigger word is stored raw and clamped where it is used, so the
        // segment length is seen through the read index wrapping back to zero.
        for (int i = 0; i < 6; i++) begin
            i_host_pc_model.wr(`REG_CTRL, SETS[i]);
            i_host_pc_model.wr(`REG_PRETRIG, 32'hFFFF);
            rdc(`REG_CTRL, "setting", SETS[i]);
            rdc(`REG_PRETRIG, "pretrig stored", 32'hFFFF);
            i_host_pc_model.wr(`REG_RDSEL, (LENS[i] - 32'h1) << `RDSEL_IDX_LSB);
            i_host_pc_model.rd(`REG_RDDATA, d);
            rdc(`REG_RDSEL, "segment length", 32'h0);
        end
        // The floor of three samples shows in the post-trigger counts below.
        i_host_pc_model.wr(`REG_PRETRIG, 32'h0);
        rdc(`REG_PRETRIG, "pretrig zero", 32'h0);
        $display("modes done");
    endtask
    task automatic t_keep();
        int n;
        logic t;
        i_host_pc_model.wr(`REG_CTRL, 32'h2);
        i_host_pc_model.wr(`REG_CTRL, 32'h8);
        for (int i = 0; i < 9; i++) begin
            repeat (8) @(posedge clock);
            pickupAny <= 1'b1;
            capture(n, t);
            pickupAny <= 1'b0;
            chk("post samples", (i < 8) ? 32'd97 : 32'd0, n);
        end
        rdc(`REG_STATUS, "status full", 32'h2708);
        $display("keep done");
    endtask
    task automatic t_over();
        int n;
        logic t;
        i_host_pc_model.wr(`REG_CTRL, 32'h17);
        for (int i = 0; i < 8; i++) begin
            repeat (8) @(posedge clock);
            tripAny <= 1'b1;
            capture(n, t);
            tripAny <= 1'b0;
            chk("post samples", 32'd97, n);
        end
        rdc(`REG_STATUS, "status ring", 32'h0717);
        i_host_pc_model.wr(`REG_RDSEL, 32'h0063_0007);
        rdc(`REG_RDDATA, "newest entry", {14'h0, lastEntry});
        $display("overwrite done");
    endtask
    task automatic t_after();
        int n;
        logic t;
        i_host_pc_model.wr(`REG_CTRL, 32'h27);
        pickupAny <= 1'b1;
        repeat (10) @(posedge clock);
        chk("busy on rise", 32'h0, {31'h0, recordBusy});
        pickupAny <= 1'b0;
        fork
            capture(n, t);
            begin
                repeat (20) @(posedge clock);
                pickupAny <= 1'b1;
                repeat (4) @(posedge clock);
                pickupAny <= 1'b0;
            end
        join
        chk("post samples", 32'd97, n);
        rdc(`REG_STATUS, "status wrap", 32'h0027);
        $display("after pickup done");
    endtask
    task automatic t_test();
        int n;
        logic t;
        reg_word_t d;
        i_host_pc_model.wr(`REG_CTRL, 32'h37);
        keyPlus <= 1'b1;
        keyMinus <= 1'b1;
        capture(n, t);
        keyPlus <= 1'b0;
        keyMinus <= 1'b0;
        chk("post samples", 32'd97, n);
        chk("test shown", 32'h1, {31'h0, t});
        i_host_pc_model.wr(`REG_CTRL, 32'h105);
        rdc(`REG_CTRL, "bad setting", 32'h7);
        i_host_pc_model.rd(`REG_STATUS, d);
        chk("cleared count", 32'h0, {28'h0, d[3:0]});
        $display("test trigger done");
    endtask

    initial begin
        #300000;
        badCount++;
        $display("[ERR] watchdog expected done seen hang");
        wrapUp();
    end
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        t_modes();
        t_keep();
        t_over();
        t_after();
        t_test();
        wrapUp();
    end
endmodule

`default_nettype wire
